//--- include/bsp_pkg.sv
package bsp_pkg;

    // Clock-stop field encodings and the tx clock polarity paired with each
    localparam logic [1:0] STOP_LATE = 2'h3;
    localparam logic [1:0] STOP_EARLY = 2'h2;
    localparam logic POL_LATE = 1'h0;
    localparam logic POL_EARLY = 1'h1;

    // Required slave generator setting: CPU clock / 4, divider 1
    localparam logic SLAVE_SRC_CPU = 1'h1;
    localparam logic [7:0] SLAVE_DIVIDER = 8'h01;

    // Generator input period in CPU clocks when fed from the CPU clock
    localparam int SRG_CPU_DIV = 4;
    localparam int HALF_TICK_CLKS = SRG_CPU_DIV / 2;
    localparam logic [1:0] HALF_TICK_LAST = 2'(HALF_TICK_CLKS - 1);

    // Slave output windows, in CPU clock periods
    localparam int SLV_FIRST_MIN_P = 8;
    localparam int SLV_FIRST_MAX_P = 16;
    localparam int SLV_SHIFT_MIN_P = 12;
    localparam int SLV_SHIFT_MAX_P = 20;
    localparam int SLV_RELEASE_MIN_P = 4;
    localparam int SLV_RELEASE_MAX_P = 12;
    // Pin to internal event latency of synchroniser and edge detect
    localparam int SYNC_LAT = 3;
    localparam int SLV_FIRST_DLY = (SLV_FIRST_MIN_P + SLV_FIRST_MAX_P) / 2 - SYNC_LAT;
    localparam int SLV_SHIFT_DLY = (SLV_SHIFT_MIN_P + SLV_SHIFT_MAX_P) / 2 - SYNC_LAT;
    localparam int SLV_RELEASE_DLY = (SLV_RELEASE_MIN_P + SLV_RELEASE_MAX_P) / 2 - SYNC_LAT;

    typedef struct packed {
        logic [1:0] clock_stop_select;
        logic tx_clock_polarity;
        logic srg_input_source_select;
        logic [7:0] srg_divider;
        logic rx_sync_polarity;
        logic tx_sync_polarity;
        logic tx_clock_source_mode;
        logic rx_clock_source_mode;
        logic tx_sync_source_mode;
        logic rx_sync_source_mode;
    } bsp_cfg_t;

    typedef enum logic [2:0] {M_IDLE, M_LEAD, M_LOW, M_HIGH, M_TAIL} bsp_mst_state_t;

    // Phase lengths in half generator-input periods
    function automatic logic [8:0] bsp_high_half(input logic [7:0] div);
        if (div != 8'h00 && !div[0]) begin
            return {1'b0, div} + 9'h002;
        end
        return {1'b0, div} + 9'h001;
    endfunction

    function automatic logic [8:0] bsp_low_half(input logic [7:0] div);
        if (div != 8'h00 && !div[0]) begin
            return {1'b0, div};
        end
        return {1'b0, div} + 9'h001;
    endfunction

endpackage

//--- hdl/bsp_buf2.sv
`timescale 1ns/1ns
module bsp_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic s_valid_i,
    output logic s_ready_o,
    input wire logic [WIDTH-1:0] s_data_i,
    output logic m_valid_o,
    input wire logic m_ready_i,
    output logic [WIDTH-1:0] m_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CNT_W-1:0] count, next_count;
    logic push, pop;

    assign s_ready_o = count != CNT_FULL;
    assign m_valid_o = count != '0;
    assign m_data_o = mem[rd_ptr];

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        push = s_valid_i && s_ready_o;
        pop = m_valid_o && m_ready_i;
        if (push) begin
            next_mem[wr_ptr] = s_data_i;
            next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem <= '{default: '0};
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

endmodule

//--- hdl/bsp_spi.sv
`timescale 1ns/1ns
// Operation
// - Support 11b with polarity 0 and 10b with polarity 1, master or slave.
// - Slave needs generator from CPU clock with divider 1, i.e. CPU/4.
// - Generator input period is four CPU clocks, or the external clock period.
// - Bit clock period is divider plus one input periods.
// - High phase: divider/2+1 if even and non-zero, else (divider+1)/2 input periods.
// - Low phase: divider/2 if even and non-zero, else (divider+1)/2 input periods.
// - Both sync polarities set; master drives select as active-low output.
// - Slave inverts active-low selects from both frame sync pins.
// - Master: tx clock and sync source modes 1, rx modes 0.
// - Slave: all four source mode bits 0, clock and select external.
// - Select falls before the first rising edge; transfer starts there.
// - Incoming data sampled on rising bit clock edge.
// - Outgoing data changes after falling edge; slave 12 to 20 cycles later.
// - Master 11b: select low one full period before first rising edge.
// - Master 11b: select held low one low phase after final falling edge.
// - 11b first bit: master high phase after select; slave 8-16 cycles.
// - Master 10b: select low one high phase before first falling edge.
// - Master 10b: select low one full period after final rising edge.
// - Master 10b: data released one high phase after last rising edge.
// - Slave 10b: data released 4 to 12 cycles after select rises.
module bsp_spi
    import bsp_pkg::*;
#(
    parameter int WORD_W = 8,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire bsp_cfg_t cfg_i,
    input wire logic srg_ext_clock_i,
    input wire logic tx_bit_clock_pin_i,
    output logic tx_bit_clock_pin_o,
    output logic tx_bit_clock_pin_oe_o,
    input wire logic tx_frame_sync_pin_i,
    output logic tx_frame_sync_pin_o,
    output logic tx_frame_sync_pin_oe_o,
    input wire logic rx_frame_sync_pin_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic [WORD_W-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [WORD_W-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic busy_o,
    output logic config_error_o,
    output logic rx_overrun_o
);
    localparam int CNT_W = $clog2(WORD_W);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);

    ////////////////////////////////////////////////////////////////////////////////
    logic variant_late, variant_ok, is_master, is_slave, cfg_ok, run;
    logic [8:0] hi_len, lo_len;

    always_comb begin
        variant_late = cfg_i.clock_stop_select == STOP_LATE;
        variant_ok = (variant_late && cfg_i.tx_clock_polarity == POL_LATE) ||
            (cfg_i.clock_stop_select == STOP_EARLY &&
            cfg_i.tx_clock_polarity == POL_EARLY);
        is_master = cfg_i.tx_clock_source_mode && cfg_i.tx_sync_source_mode &&
            !cfg_i.rx_clock_source_mode && !cfg_i.rx_sync_source_mode;
        is_slave = !cfg_i.tx_clock_source_mode && !cfg_i.tx_sync_source_mode &&
            !cfg_i.rx_clock_source_mode && !cfg_i.rx_sync_source_mode &&
            cfg_i.srg_input_source_select == SLAVE_SRC_CPU &&
            cfg_i.srg_divider == SLAVE_DIVIDER;
        cfg_ok = variant_ok && cfg_i.rx_sync_polarity && cfg_i.tx_sync_polarity &&
            (is_master || is_slave);
        run = enable_i && cfg_ok;
        hi_len = bsp_high_half(cfg_i.srg_divider);
        lo_len = bsp_low_half(cfg_i.srg_divider);
    end

    assign config_error_o = !cfg_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 1 feeds stage 2 only
    logic ck_s1, ck_s2, ck_s3, tfs_s1, tfs_s2, tfs_s3, rfs_s1, rfs_s2, rfs_s3;
    logic dr_s1, dr_s2, ext_s1, ext_s2, ext_s3;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {ck_s1, ck_s2, ck_s3, dr_s1, dr_s2, ext_s1, ext_s2, ext_s3} <= 8'h00;
            {tfs_s1, tfs_s2, tfs_s3, rfs_s1, rfs_s2, rfs_s3} <= 6'h3f;
        end else begin
            {ck_s3, ck_s2, ck_s1} <= {ck_s2, ck_s1, tx_bit_clock_pin_i};
            {tfs_s3, tfs_s2, tfs_s1} <= {tfs_s2, tfs_s1, tx_frame_sync_pin_i};
            {rfs_s3, rfs_s2, rfs_s1} <= {rfs_s2, rfs_s1, rx_frame_sync_pin_i};
            {dr_s2, dr_s1} <= {dr_s1, serial_data_in_i};
            {ext_s3, ext_s2, ext_s1} <= {ext_s2, ext_s1, srg_ext_clock_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    bsp_mst_state_t mst_state, next_mst_state;
    logic [1:0] pre, next_pre;
    logic [8:0] phase, next_phase;
    logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic [WORD_W-1:0] tx_sr, next_tx_sr, rx_sr, next_rx_sr, push_data, next_push_data;
    logic clk_pin, next_clk_pin, sel_pin, next_sel_pin, dout, next_dout;
    logic dout_oe, next_dout_oe, push_valid, next_push_valid, overrun, next_overrun;
    logic rise_seen, next_rise_seen;
    logic [SLV_FIRST_DLY-1:0] first_pipe, next_first_pipe;
    logic [SLV_SHIFT_DLY-1:0] shift_pipe, next_shift_pipe;
    logic [SLV_RELEASE_DLY-1:0] rel_pipe, next_rel_pipe;
    logic half_tick, mst_sample, buf_ready, slv_tx_sel, slv_rx_sel, shift_fire;

    always_comb begin
        next_mst_state = mst_state;
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_tx_sr = tx_sr;
        next_rx_sr = rx_sr;
        next_push_data = push_data;
        next_clk_pin = clk_pin;
        next_sel_pin = sel_pin;
        next_dout = dout;
        next_dout_oe = dout_oe;
        next_rise_seen = rise_seen;
        next_push_valid = 1'b0;
        next_overrun = 1'b0;
        tx_ready_o = 1'b0;
        mst_sample = 1'b0;
        next_first_pipe = {first_pipe[SLV_FIRST_DLY-2:0], 1'b0};
        next_shift_pipe = {shift_pipe[SLV_SHIFT_DLY-2:0], 1'b0};
        next_rel_pipe = {rel_pipe[SLV_RELEASE_DLY-2:0], 1'b0};
        shift_fire = shift_pipe[SLV_SHIFT_DLY-1];
        slv_tx_sel = !tfs_s2;
        slv_rx_sel = !rfs_s2;
        // Prescaler restarts each frame so phase lengths are exact
        next_pre = (mst_state == M_IDLE || pre == HALF_TICK_LAST) ? 2'h0 : pre + 2'h1;
        half_tick = cfg_i.srg_input_source_select ? (pre == HALF_TICK_LAST) :
            (ext_s2 != ext_s3);

        // Master: each phase counts half generator-input periods
        case (mst_state)
            M_IDLE: begin
                next_clk_pin = cfg_i.tx_clock_polarity;
                if (run && is_master && tx_valid_i && buf_ready) begin
                    tx_ready_o = 1'b1;
                    next_tx_sr = tx_data_i;
                    next_bit_cnt = '0;
                    next_sel_pin = 1'b0;
                    next_phase = hi_len - 9'h001;
                    next_mst_state = M_LEAD;
                end
            end
            M_LEAD: begin
                if (half_tick && phase == 9'h000) begin
                    next_dout = tx_sr[WORD_W-1];
                    next_dout_oe = 1'b1;
                    next_clk_pin = 1'b0;
                    next_phase = lo_len - 9'h001;
                    next_mst_state = M_LOW;
                end else if (half_tick) begin
                    next_phase = phase - 9'h001;
                end
            end
            M_LOW: begin
                if (half_tick && phase == 9'h000) begin
                    mst_sample = 1'b1;
                    next_rx_sr = {rx_sr[WORD_W-2:0], serial_data_in_i};
                    next_clk_pin = 1'b1;
                    next_phase = hi_len - 9'h001;
                    next_mst_state = M_HIGH;
                end else if (half_tick) begin
                    next_phase = phase - 9'h001;
                end
            end
            M_HIGH: begin
                if (half_tick && phase == 9'h000) begin
                    next_phase = lo_len - 9'h001;
                    if (bit_cnt == LAST_BIT) begin
                        next_dout_oe = 1'b0;
                        next_push_valid = 1'b1;
                        next_push_data = rx_sr;
                        next_clk_pin = !variant_late;
                        next_mst_state = M_TAIL;
                    end else begin
                        next_bit_cnt = bit_cnt + 1'b1;
                        next_tx_sr = tx_sr << 1;
                        next_dout = tx_sr[WORD_W-2];
                        next_clk_pin = 1'b0;
                        next_mst_state = M_LOW;
                    end
                end else if (half_tick) begin
                    next_phase = phase - 9'h001;
                end
            end
            M_TAIL: begin
                if (half_tick && phase == 9'h000) begin
                    next_sel_pin = 1'b1;
                    next_mst_state = M_IDLE;
                end else if (half_tick) begin
                    next_phase = phase - 9'h001;
                end
            end
            default: begin
                next_mst_state = M_IDLE;
            end
        endcase
        if (!run && mst_state != M_IDLE) begin
            next_mst_state = M_IDLE;
            next_sel_pin = 1'b1;
            next_dout_oe = 1'b0;
        end

        // Slave: events enter delay lines; many may be in flight at once
        if (run && is_slave) begin
            if (slv_tx_sel && tfs_s3) begin
                tx_ready_o = tx_valid_i;
                next_tx_sr = tx_valid_i ? tx_data_i : '0;
                next_rise_seen = 1'b0;
                next_first_pipe[0] = 1'b1;
            end
            if (!slv_tx_sel && !tfs_s3) begin
                next_rel_pipe[0] = 1'b1;
            end
            // No shift on a fall before the first rise, or 10b skips bit 0
            if (!ck_s2 && ck_s3 && rise_seen && slv_tx_sel) begin
                next_shift_pipe[0] = 1'b1;
            end
            if (ck_s2 && !ck_s3 && slv_tx_sel) begin
                next_rise_seen = 1'b1;
            end
            if (slv_rx_sel && rfs_s3) begin
                next_bit_cnt = '0;
            end else if (ck_s2 && !ck_s3 && slv_rx_sel) begin
                next_rx_sr = {rx_sr[WORD_W-2:0], dr_s2};
                next_bit_cnt = bit_cnt + 1'b1;
                if (bit_cnt == LAST_BIT) begin
                    next_bit_cnt = '0;
                    next_push_valid = buf_ready;
                    next_overrun = !buf_ready;
                    next_push_data = {rx_sr[WORD_W-2:0], dr_s2};
                end
            end
        end
        if (first_pipe[SLV_FIRST_DLY-1]) begin
            next_dout = tx_sr[WORD_W-1];
            next_dout_oe = 1'b1;
        end
        if (shift_fire) begin
            next_tx_sr = tx_sr << 1;
            next_dout = tx_sr[WORD_W-2];
        end
        if (rel_pipe[SLV_RELEASE_DLY-1] || (!run && is_slave)) begin
            next_dout_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mst_state <= M_IDLE;
            pre <= 2'h0;
            phase <= 9'h000;
            bit_cnt <= '0;
            tx_sr <= '0;
            rx_sr <= '0;
            push_data <= '0;
            clk_pin <= 1'b0;
            sel_pin <= 1'b1;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            push_valid <= 1'b0;
            overrun <= 1'b0;
            rise_seen <= 1'b0;
            first_pipe <= '0;
            shift_pipe <= '0;
            rel_pipe <= '0;
        end else begin
            mst_state <= next_mst_state;
            pre <= next_pre;
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            tx_sr <= next_tx_sr;
            rx_sr <= next_rx_sr;
            push_data <= next_push_data;
            clk_pin <= next_clk_pin;
            sel_pin <= next_sel_pin;
            dout <= next_dout;
            dout_oe <= next_dout_oe;
            push_valid <= next_push_valid;
            overrun <= next_overrun;
            rise_seen <= next_rise_seen;
            first_pipe <= next_first_pipe;
            shift_pipe <= next_shift_pipe;
            rel_pipe <= next_rel_pipe;
        end
    end

    assign tx_bit_clock_pin_o = clk_pin;
    assign tx_frame_sync_pin_o = sel_pin;
    assign tx_bit_clock_pin_oe_o = run && is_master;
    assign tx_frame_sync_pin_oe_o = run && is_master;
    assign serial_data_out_o = dout;
    assign serial_data_out_oe_o = dout_oe;
    assign busy_o = mst_state != M_IDLE;
    assign rx_overrun_o = overrun;

    // Received words wait here; a master frame waits for space, a slave word is dropped as overrun when full
    bsp_buf2 #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .s_valid_i(push_valid),
        .s_ready_o(buf_ready),
        .s_data_i(push_data),
        .m_valid_o(rx_valid_o),
        .m_ready_i(rx_ready_i),
        .m_data_o(rx_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic [11:0] sel_cnt, since_edge, h_cyc, l_cyc;
    logic clk_pin_d;

    assign h_cyc = 12'({hi_len, 1'b0});
    assign l_cyc = 12'({lo_len, 1'b0});

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_cnt <= 12'h000;
            since_edge <= 12'h000;
            clk_pin_d <= 1'b0;
        end else begin
            sel_cnt <= sel_pin ? 12'h000 : sel_cnt + 12'h001;
            since_edge <= (clk_pin != clk_pin_d) ? 12'h001 : since_edge + 12'h001;
            clk_pin_d <= clk_pin;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    start_cfg_a: assert property ($rose(busy_o) |-> $past(cfg_ok && is_master))
        else $error("frame started without a valid master setup");
    select_start_a: assert property ($rose(busy_o) |-> $fell(tx_frame_sync_pin_o))
        else $error("select did not fall when the frame started");
    rise_sample_a: assert property (mst_sample |=> $rose(tx_bit_clock_pin_o))
        else $error("master sampled off the rising edge");
    lead_late_a: assert property (busy_o && variant_late &&
        cfg_i.srg_input_source_select && $rose(tx_bit_clock_pin_o) && sel_cnt < h_cyc + l_cyc
        |-> 1'b0)
        else $error("first rising edge came before one full period");
    first_bit_a: assert property (variant_late && cfg_i.srg_input_source_select &&
        busy_o && $rose(serial_data_out_oe_o) |-> sel_cnt == h_cyc)
        else $error("first bit not one high phase after select");
    lead_early_a: assert property (!variant_late && cfg_i.srg_input_source_select &&
        busy_o && $fell(tx_bit_clock_pin_o) && since_edge > sel_cnt |-> sel_cnt == h_cyc)
        else $error("first falling edge not one high phase after select");
    tail_late_a: assert property (variant_late && cfg_i.srg_input_source_select &&
        $rose(tx_frame_sync_pin_o) |-> since_edge == l_cyc)
        else $error("select hold after last falling edge wrong");
    tail_early_a: assert property (!variant_late && cfg_i.srg_input_source_select &&
        $rose(tx_frame_sync_pin_o) |-> since_edge == h_cyc + l_cyc)
        else $error("select hold after last rising edge wrong");
    release_early_a: assert property (!variant_late && busy_o &&
        cfg_i.srg_input_source_select && $fell(serial_data_out_oe_o) |-> since_edge == h_cyc)
        else $error("data release not one high phase after last rise");
    slave_first_a: assert property (run && is_slave && $fell(tx_frame_sync_pin_i)
        ##1 !tx_frame_sync_pin_i [*8] |-> ##[0:8] serial_data_out_oe_o)
        else $error("slave first bit outside its window");
    slave_shift_a: assert property (run && is_slave && rise_seen && slv_tx_sel &&
        !ck_s2 && ck_s3 |-> ##[9:17] shift_fire)
        else $error("slave data change outside its window");
    slave_release_a: assert property (run && is_slave && !variant_late &&
        $rose(tx_frame_sync_pin_i) && serial_data_out_oe_o |-> ##[4:12] !serial_data_out_oe_o)
        else $error("slave data release outside its window");

    late_frame_c: cover property (variant_late && $fell(busy_o));
    early_frame_c: cover property (!variant_late && $fell(busy_o));
    slave_word_c: cover property (is_slave && push_valid);
    overrun_c: cover property (rx_overrun_o);

endmodule

//--- tb/bsp_slave_model.sv
`timescale 1ns/1ns
module bsp_slave_model (
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] rx_word_o
);
    logic [7:0] sh;
    logic seen;
    logic last = 1'b0;
    initial rx_word_o = 8'h00;
    // Load at select fall so the first bit leads the first rise
    always @(negedge ss_n_i) begin
        sh = reply_i;
        seen = 1'b0;
    end
    always @(posedge sclk_i) begin
        if (!ss_n_i) begin
            rx_word_o = {rx_word_o[6:0], mosi_i};
            seen = 1'b1;
        end
    end
    // A fall before any rise must not shift
    always @(negedge sclk_i) begin
        if (!ss_n_i && seen) begin
            sh = {sh[6:0], 1'b0};
        end
    end
    always @(posedge ss_n_i) last = sh[7];
    // Released line shows the inverse, never a stale bit
    assign miso_o = ss_n_i ? ~last : sh[7];
endmodule

//--- tb/bsp_spi_tb_top.sv
`timescale 1ns/1ns
module bsp_spi_tb_top
    import bsp_pkg::*;
;
    logic clk_i = 1'b0, reset_n_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0, stall = 1'b0;
    // Far-side master pins, used while the block is a slave
    logic m_sclk = 1'b0, m_ss_n = 1'b1, m_din = 1'b0;
    bsp_cfg_t cfg_i;
    logic [7:0] tx_data_i = 8'h00, reply = 8'h00, rx_data_o, rx_word;
    logic ck_o, ck_oe, fs_o, fs_oe, miso, dout, dout_oe, tx_ready_o, rx_valid_o, busy_o, cerr;
    int error_cnt = 0, n_tests = 0, k;
    logic [7:0] expq[$];
    wire logic sclk = ck_oe ? ck_o : m_sclk;
    wire logic ss_n = fs_oe ? fs_o : m_ss_n;
    wire logic mosi = dout_oe ? dout : ~dout;
    initial forever #50 clk_i = ~clk_i;
    bsp_spi DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(1'b1), .cfg_i(cfg_i),
        .srg_ext_clock_i(1'b0), .tx_bit_clock_pin_i(sclk), .tx_bit_clock_pin_o(ck_o),
        .tx_bit_clock_pin_oe_o(ck_oe), .tx_frame_sync_pin_i(ss_n), .tx_frame_sync_pin_o(fs_o),
        .tx_frame_sync_pin_oe_o(fs_oe), .rx_frame_sync_pin_i(ss_n),
        .serial_data_in_i(fs_oe ? miso : m_din),
        .serial_data_out_o(dout), .serial_data_out_oe_o(dout_oe), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .busy_o(busy_o),
        .config_error_o(cerr), .rx_overrun_o());
    bsp_slave_model slave (.sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .reply_i(reply),
        .miso_o(miso), .rx_word_o(rx_word));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic bsp_cfg_t mk(input logic [1:0] s, input logic [7:0] d, input logic m);
        return {s, s == STOP_EARLY, 1'h1, d, 2'h3, m, 1'h0, m, 1'h0};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cchk(input bsp_cfg_t c, input logic e);
        cfg_i <= c;
        repeat (2) @(posedge clk_i);
        chk(cerr, e, "config_error");
    endtask
    task automatic frame(input logic [1:0] s, input logic [7:0] d);
        int hh, ll, n;
        logic idle;
        logic [7:0] w, r;
        hh = (d != 0 && !d[0]) ? (d + 2) * 2 : (d + 1) * 2;
        ll = (d != 0 && !d[0]) ? d * 2 : hh;
        idle = s == STOP_EARLY;
        w = $urandom;
        r = $urandom;
        reply <= r;
        expq.push_back(r);
        cfg_i <= mk(s, d, 1'b1);
        @(posedge clk_i);
        tx_data_i <= w;
        tx_valid_i <= 1'b1;
        n = 0;
        do @(posedge clk_i); while (tx_ready_o !== 1'b1 && ++n < 500);
        tx_valid_i <= 1'b0;
        n = 0;
        do @(posedge clk_i); while (ck_o === idle && ++n < 500);
        chk(n, s == STOP_LATE ? (d + 1) * 4 : hh, "lead");
        n = 0;
        do @(posedge clk_i); while (ck_o !== idle && ++n < 500);
        chk(n + 1, s == STOP_LATE ? hh : ll, "phase");
        n = 0;
        do @(posedge clk_i); while (busy_o !== 1'b0 && ++n < 500);
        chk(rx_word, w, "mosi_word");
    endtask
    // Slow external master: 24 CPU clocks per phase, well outside the slave windows
    task automatic sframe(input logic [1:0] s);
        logic [7:0] w, r, got;
        w = $urandom;
        r = $urandom;
        expq.push_back(r);
        cfg_i <= mk(s, 8'h01, 1'b0);
        m_sclk <= s == STOP_EARLY;
        tx_data_i <= w;
        tx_valid_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        m_ss_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        tx_valid_i <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            m_sclk <= 1'b0;
            m_din <= r[b];
            repeat (24) @(posedge clk_i);
            got[b] = dout;
            m_sclk <= 1'b1;
            repeat (24) @(posedge clk_i);
        end
        m_sclk <= s == STOP_EARLY;
        repeat (24) @(posedge clk_i);
        m_ss_n <= 1'b1;
        repeat (24) @(posedge clk_i);
        chk(got, w, "slave_dout");
        chk(dout_oe, 1'b0, "slave_release");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
            chk(rx_data_o, expq.pop_front(), "rx_data");
        end
        rx_ready_i <= !stall && ($urandom % 2);
    end
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(98945));
        cfg_i = mk(STOP_LATE, 8'h01, 1'b1);
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        chk(fs_o, 1, "select_idle");
        cchk(mk(STOP_LATE, 8'h01, 1'b1), 1'b0);
        cchk(mk(STOP_EARLY, 8'h01, 1'b0), 1'b0);
        cchk(mk(STOP_LATE, 8'h02, 1'b0), 1'b1);
        cchk(mk(STOP_LATE, 8'h01, 1'b1) ^ 18'h00010, 1'b1);
        cchk(mk(STOP_LATE, 8'h01, 1'b1) ^ 18'h08000, 1'b1);
        for (int i = 0; i < 8; i++) begin
            frame(i[2] ? STOP_EARLY : STOP_LATE, 8'(i[1:0]));
        end
        sframe(STOP_LATE);
        sframe(STOP_EARLY);
        // Buffer must be empty before the stall or the second frame never starts
        repeat (30) @(posedge clk_i);
        stall = 1'b1;
        frame(STOP_LATE, 8'h01);
        frame(STOP_EARLY, 8'h01);
        tx_valid_i <= 1'b1;
        k = 0;
        repeat (100) @(posedge clk_i) k += (tx_ready_o !== 1'b0);
        chk(k, 0, "refused");
        tx_valid_i <= 1'b0;
        stall = 1'b0;
        repeat (40) @(posedge clk_i);
        chk(expq.size(), 0, "drained");
        stop_test();
    end
endmodule
